// >>> include/line_timing_pkg.sv
`default_nettype none
package line_timing_pkg;
    // APB register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] OVL_SEVEN_OFS = 8'h04;
    localparam logic [7:0] OVL_EIGHT_OFS = 8'h08;
    localparam logic [7:0] BYTE_SEVEN_OFS = 8'h0C;
    localparam logic [7:0] STATUS_OFS = 8'h10;
    localparam logic [7:0] TRIM_OFS = 8'h14;
    // Field positions
    localparam int CTRL_NT_BIT = 0;
    localparam int CTRL_MASTER_BIT = 1;
    localparam int CTRL_TXBAUD_BIT = 2;
    localparam int OVL_SEVEN_RATE_BIT = 4;
    localparam int OVL_EIGHT_FREF_OE_BIT = 4;
    localparam int BYTE_SEVEN_RATE_BIT = 2;
    // Reset values
    localparam logic [7:0] TRIM_RESET = 8'h80;
    // Clock and reference rates in Hz
    localparam longint CLK_HZ = 20000000;
    localparam longint REF_HZ = 8000;
    localparam longint BAUD_HZ = 80000;
    localparam longint DCL_512_HZ = 512000;
    localparam longint DCL_2048_HZ = 2048000;
    localparam longint DCL_2560_HZ = 2560000;
    // Timing counts derived from the rates
    localparam logic [11:0] REF_PERIOD = 12'(CLK_HZ / REF_HZ);
    localparam logic [11:0] BAUD_PERIOD = 12'(CLK_HZ / BAUD_HZ);
    localparam logic [3:0] BAUDS_PER_FRAME = 4'(BAUD_HZ / REF_HZ);
    localparam logic [11:0] LT_TOLERANCE = 12'h002;
    localparam logic [11:0] NT_TOLERANCE = 12'h001;
    localparam logic [3:0] LOCK_COUNT = 4'h8;
    // NCO increments for a 16-bit phase accumulator
    localparam logic [15:0] INC_512 = 16'((DCL_512_HZ * 65536) / CLK_HZ);
    localparam logic [15:0] INC_2048 = 16'((DCL_2048_HZ * 65536) / CLK_HZ);
    localparam logic [15:0] INC_2560 = 16'((DCL_2560_HZ * 65536) / CLK_HZ);

    typedef enum {ACQUIRE, LOCKED} lock_state_t;

    // Software configuration gathered from the register file
    typedef struct packed {
        logic network_termination_mode;
        logic gci_master;
        logic transmit_baud_clock;
        logic init_overlay_seven_rate;
        logic init_overlay_eight_fref_oe;
        logic byte_register_seven_rate;
    } cfg_t;
endpackage
`default_nettype wire

// >>> src/line_timing_clock_select.sv
// Contract
// RQ1 - LT: lock oscillator trim to 8 kHz reference
// RQ2 - NT: no reference, timing from line
// RQ3 - MCU NT: overlay-eight bit4 drives DCL out
// RQ4 - DCL rate from byte-seven b2, overlay-seven b4
// RQ5 - GCI: locked output unless transmit baud enabled; the code drives it in NT mode only, never in LT
// RQ6 - GCI NT: rate pin picks 512k/2.048M
// RQ7 - NT DCL synced, 512k/2.048M/2.56M
// RQ8 - NT buffered oscillator not a synced master
// RQ9 - NT locks to 80 kbaud line timing
// RQ10 - Rate pin high 2.048M, low 512k
// RQ11 - GCI master: no locked output, DCL instead
// RQ12 - Reference pin input until output enabled
//
// Decided for this implementation: register access over APB and the register offsets.
`default_nettype none
module line_timing_clock_select
    import line_timing_pkg::*;
(
    // Clock and reset
    input wire logic CLK,
    input wire logic RST_B,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Pins
    input wire logic HOST_IF_SEL,
    input wire logic RATE_SELECT_PIN,
    input wire logic LINE_BAUD_STROBE,
    input wire logic FREQ_REF_IN,
    output logic FREQ_REF_OUT,
    output logic FREQ_REF_OE,
    output logic DCL_OUT,
    output logic LOCKED_FREQ_OUT,
    output logic OSC_TRIM_UP,
    output logic [7:0] OSC_TRIM
);
    cfg_t cfg_q;
    logic [2:0] ref_sync_q, baud_sync_q;
    logic [1:0] rate_sync_q, host_sync_q;
    logic [11:0] period_q, period_d;
    logic [3:0] good_q, good_d, baud_cnt_q, baud_cnt_d;
    logic [7:0] trim_q, trim_d;
    logic [15:0] acc_q, acc_d, inc;
    logic [31:0] rdata;
    lock_state_t lock_q, lock_d;
    logic pready_q, pslverr_q, dcl_q, locked_out_q, fref_out_q, fref_oe_q, trim_up_q;
    logic [31:0] prdata_q;

    // Two-flop synchronisers; edge stages reset high so a high pin gives no false edge
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            ref_sync_q <= 3'h7;
            baud_sync_q <= 3'h7;
            rate_sync_q <= 2'h0;
            host_sync_q <= 2'h0;
        end else begin
            ref_sync_q <= {ref_sync_q[1:0], FREQ_REF_IN};
            baud_sync_q <= {baud_sync_q[1:0], LINE_BAUD_STROBE};
            rate_sync_q <= {rate_sync_q[0], RATE_SELECT_PIN};
            host_sync_q <= {host_sync_q[0], HOST_IF_SEL};
        end
    end

    // Mode decoding
    wire nt = cfg_q.network_termination_mode;
    wire mcu_mode = host_sync_q[1];
    wire ref_rise = ref_sync_q[1] & ~ref_sync_q[2];
    wire baud_rise = baud_sync_q[1] & ~baud_sync_q[2];
    wire fref_driving = mcu_mode & nt & cfg_q.init_overlay_eight_fref_oe; // see RQ3 see RQ12
    // Reference pin is ignored while it is being driven by us
    wire ref_edge = nt ? baud_rise : (ref_rise & ~fref_driving); // see RQ1 see RQ2
    wire [11:0] nominal = nt ? BAUD_PERIOD : REF_PERIOD; // see RQ9
    wire [11:0] tol = nt ? NT_TOLERANCE : LT_TOLERANCE;
    wire period_slow = period_q > (nominal + tol);
    wire period_fast = period_q < (nominal - tol);
    wire period_ok = ~period_slow & ~period_fast;
    wire timeout = period_q == 12'hFFF;

    // Rate choice: MCU from register bits, GCI from the pin
    wire [1:0] mcu_rate = {cfg_q.byte_register_seven_rate, cfg_q.init_overlay_seven_rate};
    always_comb begin
        if (!mcu_mode) begin
            inc = rate_sync_q[1] ? INC_2048 : INC_512; // see RQ6 see RQ10
        end else begin
            case (mcu_rate) // see RQ4 see RQ7
                2'b00: inc = INC_512;
                2'b10: inc = INC_2048;
                default: inc = INC_2560;
            endcase
        end
    end

    // Period measurement and lock tracking
    always_comb begin
        period_d = timeout ? period_q : period_q + 12'h001;
        good_d = good_q;
        lock_d = lock_q;
        trim_d = trim_q;
        if (timeout) begin
            lock_d = ACQUIRE;
            good_d = 4'h0;
        end
        if (ref_edge) begin
            period_d = 12'h001;
            // A long period means our clock is fast: pull the oscillator down
            if (period_slow && trim_q != 8'h00) begin
                trim_d = trim_q - 8'h01; // see RQ1
            end else if (period_fast && trim_q != 8'hFF) begin
                trim_d = trim_q + 8'h01;
            end
            case (lock_q)
                ACQUIRE: begin
                    good_d = period_ok ? good_q + 4'h1 : 4'h0;
                    if (period_ok && good_q == LOCK_COUNT - 4'h1) begin
                        lock_d = LOCKED; // see RQ9
                    end
                end
                LOCKED: begin
                    if (!period_ok) begin
                        lock_d = ACQUIRE;
                        good_d = 4'h0;
                    end
                end
                default: lock_d = ACQUIRE;
            endcase
        end
    end

    // Frame position: ten bauds make one 8 kHz frame
    always_comb begin
        baud_cnt_d = baud_cnt_q;
        if (nt && baud_rise) begin
            baud_cnt_d = (baud_cnt_q == BAUDS_PER_FRAME - 4'h1) ? 4'h0 : baud_cnt_q + 4'h1;
        end
    end
    // Restart the NCO on each frame boundary so DCL follows line timing
    wire frame_sync = nt ? (baud_rise && baud_cnt_q == BAUDS_PER_FRAME - 4'h1) : ref_edge;
    assign acc_d = frame_sync ? 16'h0000 : acc_q + inc; // see RQ7

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            period_q <= 12'h000;
            good_q <= 4'h0;
            lock_q <= ACQUIRE;
            trim_q <= TRIM_RESET;
            baud_cnt_q <= 4'h0;
            acc_q <= 16'h0000;
        end else begin
            period_q <= period_d;
            good_q <= good_d;
            lock_q <= lock_d;
            trim_q <= trim_d;
            baud_cnt_q <= baud_cnt_d;
            acc_q <= acc_d;
        end
    end

    // Clock pin steering
    wire dcl_next = acc_d[15];
    wire gci_slave_out = ~mcu_mode & nt & ~cfg_q.gci_master & ~cfg_q.transmit_baud_clock;
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            dcl_q <= 1'b0;
            locked_out_q <= 1'b0;
            fref_out_q <= 1'b0;
            fref_oe_q <= 1'b0;
            trim_up_q <= 1'b0;
        end else begin
            dcl_q <= dcl_next;
            locked_out_q <= gci_slave_out & dcl_next; // see RQ5 see RQ11
            fref_out_q <= fref_driving & dcl_next; // see RQ3
            fref_oe_q <= fref_driving; // see RQ12
            trim_up_q <= ref_edge & period_fast & (trim_q != 8'hFF); // No pulse at the ceiling
        end
    end

    // Register read mux
    wire [7:0] status = {4'h0, fref_driving, mcu_mode, nt, lock_q == LOCKED};
    always_comb begin
        case (PADDR)
            CTRL_OFS: rdata = {29'h0, cfg_q.transmit_baud_clock, cfg_q.gci_master, nt};
            OVL_SEVEN_OFS: rdata = {27'h0, cfg_q.init_overlay_seven_rate, 4'h0};
            OVL_EIGHT_OFS: rdata = {27'h0, cfg_q.init_overlay_eight_fref_oe, 4'h0};
            BYTE_SEVEN_OFS: rdata = {29'h0, cfg_q.byte_register_seven_rate, 2'h0};
            STATUS_OFS: rdata = {24'h0, status};
            TRIM_OFS: rdata = {24'h0, trim_q};
            default: rdata = 32'h0000_0000;
        endcase
    end
    wire mapped = PADDR == CTRL_OFS || PADDR == OVL_SEVEN_OFS || PADDR == OVL_EIGHT_OFS ||
                  PADDR == BYTE_SEVEN_OFS || PADDR == STATUS_OFS || PADDR == TRIM_OFS;
    // One wait state so every bus output leaves a flop
    wire access = PSEL & PENABLE & ~pready_q;
    wire wr_done = PSEL & PENABLE & pready_q & PWRITE;

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= access;
            pslverr_q <= access & ~mapped;
            prdata_q <= (access & ~PWRITE) ? rdata : 32'h0000_0000;
        end
    end

    // Configuration writes
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            cfg_q <= '0;
        end else if (wr_done) begin
            if (PADDR == CTRL_OFS) begin
                cfg_q.network_termination_mode <= PWDATA[CTRL_NT_BIT];
                cfg_q.gci_master <= PWDATA[CTRL_MASTER_BIT];
                cfg_q.transmit_baud_clock <= PWDATA[CTRL_TXBAUD_BIT];
            end
            if (PADDR == OVL_SEVEN_OFS) begin
                cfg_q.init_overlay_seven_rate <= PWDATA[OVL_SEVEN_RATE_BIT];
            end
            if (PADDR == OVL_EIGHT_OFS) begin
                cfg_q.init_overlay_eight_fref_oe <= PWDATA[OVL_EIGHT_FREF_OE_BIT];
            end
            if (PADDR == BYTE_SEVEN_OFS) begin
                cfg_q.byte_register_seven_rate <= PWDATA[BYTE_SEVEN_RATE_BIT];
            end
        end
    end

    // Outputs straight from flops
    assign PRDATA = prdata_q;
    assign PREADY = pready_q;
    assign PSLVERR = pslverr_q;
    assign FREQ_REF_OUT = fref_out_q;
    assign FREQ_REF_OE = fref_oe_q;
    assign DCL_OUT = dcl_q;
    assign LOCKED_FREQ_OUT = locked_out_q;
    assign OSC_TRIM_UP = trim_up_q;
    assign OSC_TRIM = trim_q;
endmodule // line_timing_clock_select
`default_nettype wire

// >>> dv/line_timing_asserts.sv
`default_nettype none
module line_timing_asserts (
    // Clock, reset, bus and mode pin
    input wire logic CLK, RST_B, PSEL, PENABLE, PREADY, PSLVERR, HOST_IF_SEL,
    input wire logic [31:0] PRDATA,
    // Clock outputs and trim
    input wire logic FREQ_REF_OUT, FREQ_REF_OE, DCL_OUT, LOCKED_FREQ_OUT, OSC_TRIM_UP,
    input wire logic [7:0] OSC_TRIM
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);
    // Bus answer timing, one wait state
    property p_ready_wait; PSEL && PENABLE && !$past(PENABLE) |-> !PREADY ##1 PREADY; endproperty
    a_ready_wait: assert property (p_ready_wait) else $error("ready not after one wait");
    property p_ready_pulse; PREADY |=> !PREADY; endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready longer than one cycle");
    property p_err_ready; PSLVERR |-> PREADY; endproperty
    a_err_ready: assert property (p_err_ready) else $error("error without ready");
    property p_rdata_idle; !PREADY |-> PRDATA == 32'h0; endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside answer");
    // Reference pin driven only in host-register mode, a copy of the data clock
    property p_oe_mcu; (!HOST_IF_SEL) [*5] |-> !FREQ_REF_OE; endproperty
    a_oe_mcu: assert property (p_oe_mcu) else $error("ref pin driven in serial mode");
    property p_ref_quiet; !FREQ_REF_OE |-> !FREQ_REF_OUT; endproperty
    a_ref_quiet: assert property (p_ref_quiet) else $error("ref out while input");
    property p_ref_copy;
        FREQ_REF_OE && $past(FREQ_REF_OE) |-> (FREQ_REF_OUT == DCL_OUT || FREQ_REF_OUT == $past(DCL_OUT));
    endproperty
    a_ref_copy: assert property (p_ref_copy) else $error("ref out not the data clock");
    // Locked output silent in host-register mode, follows the data clock only in NT slave mode without the transmit baud clock
    property p_lfo_gci; HOST_IF_SEL [*5] |-> !LOCKED_FREQ_OUT; endproperty
    a_lfo_gci: assert property (p_lfo_gci) else $error("locked out in host mode");
    property p_lfo_copy; LOCKED_FREQ_OUT |-> DCL_OUT || $past(DCL_OUT); endproperty
    a_lfo_copy: assert property (p_lfo_copy) else $error("locked out not the data clock");
    // Trim step pulse goes with a raised trim word
    property p_trim_up; OSC_TRIM_UP |-> OSC_TRIM > $past(OSC_TRIM, 2); endproperty
    a_trim_up: assert property (p_trim_up) else $error("trim pulse without step");
    c_err: cover property (PSLVERR);
    c_oe: cover property ($rose(FREQ_REF_OE));
    c_lfo: cover property ($rose(LOCKED_FREQ_OUT));
    c_trim: cover property (OSC_TRIM_UP);
endmodule // line_timing_asserts
`default_nettype wire

// >>> dv/line_ref_source.sv
`default_nettype none
module line_ref_source (
    // Clock and period settings
    input wire logic clk,
    input wire logic [11:0] ref_period,
    input wire logic [11:0] baud_period,
    // Timing outputs
    output logic ref_clk,
    output logic baud_strobe
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [11:0] ref_q = 12'h000;
    logic [11:0] baud_q = 12'h000;
    // Free running counters; a period change applies at once, to the cycle in progress
    always_ff @(posedge clk) begin
        ref_q <= (ref_q >= ref_period - 12'h001) ? 12'h000 : ref_q + 12'h001;
        baud_q <= (baud_q >= baud_period - 12'h001) ? 12'h000 : baud_q + 12'h001;
    end
    // Exchange reference and recovered line timing, both half high
    assign ref_clk = ref_q < (ref_period >> 1);
    assign baud_strobe = baud_q < (baud_period >> 1);
    // No buffered oscillator output is taken as a master clock here
endmodule // line_ref_source
`default_nettype wire

// >>> dv/tb_line_timing_clock_select.sv
`default_nettype none
module tb_line_timing_clock_select import line_timing_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ns;
    logic CLK = 1'b0, RST_B = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
    logic [7:0] PADDR = 8'h00, OSC_TRIM;
    logic [31:0] PWDATA = 32'h0, PRDATA, seed = 32'h0000AD23;
    logic PREADY, PSLVERR, HOST_IF_SEL = 1'b1, RATE_SELECT_PIN = 1'b0, LINE_BAUD_STROBE;
    logic FREQ_REF_IN, FREQ_REF_OUT, FREQ_REF_OE, DCL_OUT, LOCKED_FREQ_OUT, OSC_TRIM_UP;
    logic [11:0] ref_per = REF_PERIOD, baud_per = BAUD_PERIOD;
    logic [33:0] exp_q[$];
    int num_errors = 0, num_checks = 0, dcl_n = 0, lfo_n = 0, up_n = 0;
    longint hz_mcu[4] = '{DCL_512_HZ, DCL_2560_HZ, DCL_2048_HZ, DCL_2560_HZ};
    initial forever #25 CLK = ~CLK;
    line_timing_clock_select DUT (.CLK, .RST_B, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
        .PRDATA, .PREADY, .PSLVERR, .HOST_IF_SEL, .RATE_SELECT_PIN, .LINE_BAUD_STROBE,
        .FREQ_REF_IN, .FREQ_REF_OUT, .FREQ_REF_OE, .DCL_OUT, .LOCKED_FREQ_OUT, .OSC_TRIM_UP,
        .OSC_TRIM);
    line_ref_source u_src (.clk(CLK), .ref_period(ref_per), .baud_period(baud_per),
        .ref_clk(FREQ_REF_IN), .baud_strobe(LINE_BAUD_STROBE));
    function automatic logic [31:0] xs(input logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic test_done;
        if (num_errors == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // One bus transfer; an idle edge first keeps drivers single per time step
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [33:0] e);
        int n;
        @(posedge CLK);
        exp_q.push_back(e);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1'b1;
        n = 0;
        // Hold the request until ready is seen high at a rising edge
        do begin
            @(posedge CLK);
            n++;
        end while (PREADY !== 1'b1 && n < 20);
        if (PREADY !== 1'b1) begin
            check(32'h0, 32'h1, "ready timeout");
            test_done();
        end
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic err);
        apb(1'b0, a, 32'h0, {1'b1, err, d});
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, {2'b00, 32'h0});
    endtask
    // Edge count over a window against the nominal rate, a few edges of slack
    task automatic rate(input longint hz, input logic lfo, input string what);
        int d0, l0, n;
        d0 = dcl_n;
        l0 = lfo_n;
        n = int'(hz * 2500 / CLK_HZ);
        repeat (2500) @(posedge CLK);
        check(32'((lfo ? lfo_n - l0 : dcl_n - d0) inside {[n - 3:n + 3]}), 32'h1, what);
    endtask
    // Edge counters for the DCL_OUT and LOCKED_FREQ_OUT clock outputs and trim pulses
    always @(posedge DCL_OUT) dcl_n++;
    always @(posedge LOCKED_FREQ_OUT) lfo_n++;
    always @(negedge CLK) if (OSC_TRIM_UP === 1'b1) up_n++;
    // Answer monitor takes the oldest note at the edge that ends the access
    always @(posedge CLK) begin
        logic [33:0] e;
        if (PREADY === 1'b1) begin
            e = (exp_q.size() > 0) ? exp_q.pop_front() : 34'h3FFFFFFFF;
            check(32'(PSLVERR), 32'(e[32]), "slave error");
            if (e[33]) check(PRDATA, e[31:0], "read data");
        end
    end
    initial begin
        int u0;
        repeat (10) @(posedge CLK);
        RST_B <= 1'b1;
        repeat (3) @(posedge CLK);
        rd(CTRL_OFS, 32'h0, 1'b0);
        rd(STATUS_OFS, 32'h4, 1'b0);
        wr(TRIM_OFS, 32'h0);
        rd(TRIM_OFS, {24'h0, TRIM_RESET}, 1'b0);
        apb(1'b1, 8'h18, 32'hFFFFFFFF, {2'b01, 32'h0});
        rd(8'h18, 32'h0, 1'b1);
        for (int k = 0; k < 3; k++) begin
            seed = xs(seed);
            wr(OVL_SEVEN_OFS, seed);
            rd(OVL_SEVEN_OFS, seed & 32'h10, 1'b0);
        end
        wr(OVL_EIGHT_OFS, 32'h10);
        repeat (4) @(posedge CLK);
        check(FREQ_REF_OE, 32'h0, "ref pin in LT");
        wr(CTRL_OFS, 32'h1);
        repeat (4) @(posedge CLK);
        check(FREQ_REF_OE, 32'h1, "ref pin in NT");
        for (int i = 0; i < 4; i++) begin
            wr(BYTE_SEVEN_OFS, {29'h0, i[1], 2'b00});
            wr(OVL_SEVEN_OFS, {27'h0, i[0], 4'h0});
            rate(hz_mcu[i], 1'b0, "dcl rate");
        end
        rd(STATUS_OFS, 32'hF, 1'b0);
        ref_per <= 12'hBB8;
        repeat (6000) @(posedge CLK);
        rd(STATUS_OFS, 32'hF, 1'b0);
        baud_per <= BAUD_PERIOD + 12'h002;
        repeat (1000) @(posedge CLK);
        rd(STATUS_OFS, 32'hE, 1'b0);
        baud_per <= BAUD_PERIOD;
        HOST_IF_SEL <= 1'b0;
        repeat (6) @(posedge CLK);
        check(FREQ_REF_OE, 32'h0, "ref pin in GCI");
        for (int p = 0; p < 2; p++) begin
            RATE_SELECT_PIN <= p[0];
            rate(p[0] ? DCL_2048_HZ : DCL_512_HZ, 1'b1, "locked rate");
        end
        wr(CTRL_OFS, 32'h5);
        rate(0, 1'b1, "locked with baud clock");
        wr(CTRL_OFS, 32'h3);
        rate(0, 1'b1, "locked as master");
        rate(DCL_2048_HZ, 1'b0, "master dcl rate");
        wr(CTRL_OFS, 32'h0);
        ref_per <= REF_PERIOD;
        repeat (25000) @(posedge CLK);
        rd(STATUS_OFS, 32'h1, 1'b0);
        u0 = up_n;
        ref_per <= REF_PERIOD - 12'h064;
        repeat (6000) @(posedge CLK);
        rd(STATUS_OFS, 32'h0, 1'b0);
        check(32'(up_n > u0), 32'h1, "trim steps up");
        test_done();
    end
endmodule // tb_line_timing_clock_select
bind line_timing_clock_select line_timing_asserts u_chk (.CLK, .RST_B, .PSEL, .PENABLE,
    .PREADY, .PSLVERR, .HOST_IF_SEL, .PRDATA, .FREQ_REF_OUT, .FREQ_REF_OE, .DCL_OUT,
    .LOCKED_FREQ_OUT, .OSC_TRIM_UP, .OSC_TRIM);
`default_nettype wire
